//--- src/eepr_pkg.sv
// Shared constants and types of the serial EEPROM access logic
package eepr_pkg;
    // Clock and self-timed write cycle; longest time rounds down
    localparam int CLK_PERIOD_NS = 50;
    localparam int WR_TIME_NS = 10_000_000;
    localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;
    // Array organisation
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int ARRAY_BYTES = 256;
    localparam int FIFO_DEPTH = 32;
    // Page writes advance only this many low address bits
    localparam int PAGE_BITS = 4;
    // Slave address byte fields
    localparam logic [3:0] MEM_NIBBLE = 4'ha;
    localparam logic [3:0] REG_NIBBLE = 4'h6;
    localparam int NIB_HI = 7;
    localparam int NIB_LO = 4;
    localparam int CS_HI = 3;
    localparam int CS_LO = 1;
    localparam int RW_BIT = 0;
    // Protected half is selected by the address msb being zero
    localparam int PROT_BIT = 7;
    // Bit counter values
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WADDR, ST_WADDR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_WAIT_STOP, ST_PROG
    } eepr_state_t;
endpackage : eepr_pkg

//--- src/eepr_fifo.sv
// Parameterised FIFO holding page write entries until the write cycle
`timescale 1ns/1ps
module eepr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = eepr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("eepr_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0] wptr;
    logic [PW:0] rptr;
    logic [PW:0] next_wptr;
    logic [PW:0] next_rptr;
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign o_ready = (wptr ^ rptr) != {1'b1, {PW{1'b0}}};
    assign o_valid = wptr != rptr;
    assign o_data = store[rptr[PW-1:0]];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        if (push) begin
            next_wptr = wptr + 1'b1;
        end
        if (pop) begin
            next_rptr = rptr + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            store[wptr[PW-1:0]] <= i_data;
        end
    end
endmodule : eepr_fifo

//--- src/eepr_core.sv
// Two-wire slave access logic of a 256-byte EEPROM with write protection
// How it works
// - Stop after write starts the write cycle
// - Master may poll right after stop
// - No address acknowledge while write cycle runs
// - Acknowledge polling address once cycle finished
// - Protect pin high makes array read-only
// - Protect pin high refuses protection register
// - Pin low allows writes except locked half
// - Programmed register locks lowest 128 bytes
// - Register writable once, survives reset
// - Register addressed with nibble 0110
// - No acknowledge to register after first access
// - Read addresses like write, direction one
// - Counter holds last accessed address plus one
// - Current read wraps from 255 to 0
// - Current read: ack address, send byte
// - Byte address loads counter, then byte returned
// - Master acknowledge fetches next byte
// - Master no-acknowledge ends read, await stop
// - Read increments all bits, wraps 256
// - Address: nibble 1010, chip select, direction
// - Bus interface silent during write cycle
// - Page write increments low four bits
`timescale 1ns/1ps
module eepr_core #(
    parameter int WR_CYCLES = eepr_pkg::WR_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Two-wire bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Straps
    input wire logic [2:0] i_chip_select_inputs,
    input wire logic i_wp,
    // Nonvolatile protection cell
    input wire logic i_swp_stored,
    output logic o_swp_program,
    // Status
    output logic o_busy
);
    localparam int TMR_W = $clog2(WR_CYCLES + 1);
    localparam int AW = eepr_pkg::ADDR_W;
    localparam int DW = eepr_pkg::DATA_W;
    localparam int EW = AW + DW;

    initial begin
        if (WR_CYCLES < 1) begin
            $error("eepr_core: WR_CYCLES must be at least 1");
        end
    end

    // Advance the address counter, page writes keep the upper nibble
    function automatic logic [AW-1:0] eepr_inc(input logic [AW-1:0] a, input logic page);
        if (page) begin
            eepr_inc = {a[AW-1:eepr_pkg::PAGE_BITS], a[eepr_pkg::PAGE_BITS-1:0] + 1'b1};
        end else begin
            eepr_inc = a + 8'h01;
        end
    endfunction : eepr_inc

    // Two-flop synchronisers for every pin input
    logic [3:0] sync_m;
    logic [3:0] sync_s;
    logic scl_d;
    logic sda_d;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic swp_nv;
    logic [2:0] cs_s;
    logic [2:0] cs_m;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_m <= 4'h3;
            sync_s <= 4'h3;
            cs_m <= 3'h0;
            cs_s <= 3'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            sync_m <= {i_swp_stored, i_wp, i_scl, i_sda};
            sync_s <= sync_m;
            cs_m <= i_chip_select_inputs;
            cs_s <= cs_m;
            scl_d <= sync_s[1];
            sda_d <= sync_s[0];
        end
    end

    assign scl_s = sync_s[1];
    assign sda_s = sync_s[0];
    assign wp_s = sync_s[2];
    assign swp_nv = sync_s[3];

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;

    // Controller state
    eepr_pkg::eepr_state_t state;
    eepr_pkg::eepr_state_t next_state;
    logic [3:0] bitcnt;
    logic [3:0] next_bitcnt;
    logic [DW-1:0] shreg;
    logic [DW-1:0] next_shreg;
    logic oe;
    logic next_oe;
    logic [AW-1:0] addr_cnt;
    logic [AW-1:0] next_addr_cnt;
    logic is_reg;
    logic next_is_reg;
    logic mack;
    logic next_mack;
    logic wr_pend;
    logic next_wr_pend;
    logic reg_pend;
    logic next_reg_pend;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] next_tmr;
    logic swp_wr;
    logic next_swp_wr;
    logic swp_prog;
    logic next_swp_prog;
    logic swp;
    logic prot;
    logic cs_ok;

    // Page buffer and array
    logic [DW-1:0] array_mem [eepr_pkg::ARRAY_BYTES];
    logic push;
    logic fifo_ready;
    logic fifo_valid;
    logic drain;
    logic [EW-1:0] fifo_out;
    logic [DW-1:0] rd_byte;

    // Protection stays set across resets through the nonvolatile cell
    // persistent one-time lock
    assign swp = swp_nv || swp_wr;
    assign prot = wp_s || (swp && !addr_cnt[eepr_pkg::PROT_BIT]);
    assign cs_ok = shreg[eepr_pkg::CS_HI:eepr_pkg::CS_LO] == cs_s;
    assign rd_byte = array_mem[addr_cnt];
    assign drain = state == eepr_pkg::ST_PROG;

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_oe = oe;
        next_addr_cnt = addr_cnt;
        next_is_reg = is_reg;
        next_mack = mack;
        next_wr_pend = wr_pend;
        next_reg_pend = reg_pend;
        next_tmr = tmr;
        next_swp_wr = swp_wr;
        next_swp_prog = 1'b0;
        push = 1'b0;
        if (state == eepr_pkg::ST_PROG) begin
            next_oe = 1'b0;
            if (reg_pend) begin
                next_swp_wr = 1'b1;
                next_swp_prog = 1'b1;
                next_reg_pend = 1'b0;
            end
            if (tmr != TMR_W'(WR_CYCLES - 1)) begin
                next_tmr = tmr + 1'b1;
            end else if (!fifo_valid) begin
                next_state = eepr_pkg::ST_IDLE;
                next_wr_pend = 1'b0;
                next_tmr = '0;
            end
        end else if (start_det) begin
            next_state = eepr_pkg::ST_ADDR;
            next_bitcnt = eepr_pkg::BIT_ZERO;
            next_oe = 1'b0;
        end else if (stop_det) begin
            next_oe = 1'b0;
            if (wr_pend || reg_pend) begin
                next_state = eepr_pkg::ST_PROG;
                next_tmr = '0;
            end else begin
                next_state = eepr_pkg::ST_IDLE;
            end
        end else begin
            case (state)
                eepr_pkg::ST_ADDR, eepr_pkg::ST_WADDR, eepr_pkg::ST_WDATA: begin
                    if (scl_rise && bitcnt != eepr_pkg::BIT_LAST) begin
                        next_shreg = {shreg[DW-2:0], sda_s};
                        next_bitcnt = bitcnt + 1'b1;
                    end else if (scl_fall && bitcnt == eepr_pkg::BIT_LAST) begin
                        next_bitcnt = eepr_pkg::BIT_ZERO;
                        next_oe = 1'b1;
                        if (state == eepr_pkg::ST_ADDR) begin
                            next_state = eepr_pkg::ST_ADDR_ACK;
                            if (shreg[eepr_pkg::NIB_HI:eepr_pkg::NIB_LO] == eepr_pkg::MEM_NIBBLE && cs_ok) begin
                                next_is_reg = 1'b0;
                            end else if (shreg[eepr_pkg::NIB_HI:eepr_pkg::NIB_LO] == eepr_pkg::REG_NIBBLE && cs_ok
                                && !shreg[eepr_pkg::RW_BIT] && !swp && !wp_s) begin
                                next_is_reg = 1'b1;
                            end else begin
                                next_oe = 1'b0;
                                next_state = eepr_pkg::ST_IDLE;
                            end
                        end else if (state == eepr_pkg::ST_WADDR) begin
                            next_state = eepr_pkg::ST_WADDR_ACK;
                            if (!is_reg) begin
                                next_addr_cnt = shreg;
                            end
                        end else if (is_reg) begin
                            next_state = eepr_pkg::ST_WDATA_ACK;
                            next_reg_pend = !wp_s;
                        end else if (!prot && !fifo_ready) begin
                            // Page buffer full: refuse the byte
                            next_oe = 1'b0;
                            next_state = eepr_pkg::ST_IDLE;
                        end else begin
                            next_state = eepr_pkg::ST_WDATA_ACK;
                            push = !prot;
                            next_wr_pend = wr_pend || !prot;
                            next_addr_cnt = eepr_inc(addr_cnt, 1'b1);
                        end
                    end
                end
                eepr_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shreg[eepr_pkg::RW_BIT]) begin
                            // first data bit after address ack
                            next_state = eepr_pkg::ST_RDATA;
                            next_shreg = rd_byte;
                            next_oe = !rd_byte[DW-1];
                            next_bitcnt = eepr_pkg::BIT_FIRST;
                        end else begin
                            next_state = eepr_pkg::ST_WADDR;
                            next_oe = 1'b0;
                        end
                    end
                end
                eepr_pkg::ST_WADDR_ACK, eepr_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_state = eepr_pkg::ST_WDATA;
                        next_oe = 1'b0;
                    end
                end
                eepr_pkg::ST_RDATA: begin
                    if (scl_fall && bitcnt != eepr_pkg::BIT_LAST) begin
                        next_shreg = {shreg[DW-2:0], 1'b0};
                        next_oe = !shreg[DW-2];
                        next_bitcnt = bitcnt + 1'b1;
                    end else if (scl_fall) begin
                        next_oe = 1'b0;
                        next_state = eepr_pkg::ST_RACK;
                        next_addr_cnt = eepr_inc(addr_cnt, 1'b0);
                    end
                end
                eepr_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        next_mack = !sda_s;
                    end else if (scl_fall) begin
                        if (mack) begin
                            next_state = eepr_pkg::ST_RDATA;
                            next_shreg = rd_byte;
                            next_oe = !rd_byte[DW-1];
                            next_bitcnt = eepr_pkg::BIT_FIRST;
                        end else begin
                            next_state = eepr_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                default: begin
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= eepr_pkg::ST_IDLE;
            bitcnt <= eepr_pkg::BIT_ZERO;
            shreg <= '0;
            oe <= 1'b0;
            addr_cnt <= '0;
            is_reg <= 1'b0;
            mack <= 1'b0;
            wr_pend <= 1'b0;
            reg_pend <= 1'b0;
            tmr <= '0;
            swp_wr <= 1'b0;
            swp_prog <= 1'b0;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            oe <= next_oe;
            addr_cnt <= next_addr_cnt;
            is_reg <= next_is_reg;
            mack <= next_mack;
            wr_pend <= next_wr_pend;
            reg_pend <= next_reg_pend;
            tmr <= next_tmr;
            swp_wr <= next_swp_wr;
            swp_prog <= next_swp_prog;
        end
    end

    eepr_fifo #(
        .WIDTH(EW),
        .DEPTH(eepr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_valid(push),
        .o_ready(fifo_ready),
        .i_data({addr_cnt, shreg}),
        .o_valid(fifo_valid),
        .i_ready(drain),
        .o_data(fifo_out)
    );

    // Later entries to the same address overwrite earlier ones
    always_ff @(posedge i_clk_sys) begin
        if (drain && fifo_valid) begin
            array_mem[fifo_out[EW-1:DW]] <= fifo_out[DW-1:0];
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = oe;
    assign o_swp_program = swp_prog;
    assign o_busy = state == eepr_pkg::ST_PROG;

    property p_busy_silent;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        state == eepr_pkg::ST_PROG |=> !o_sda_oe;
    endproperty
    a_busy_silent: assert property (p_busy_silent) else $error("data line driven during write cycle");

    property p_stop_prog;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (state != eepr_pkg::ST_PROG && stop_det && wr_pend) |=> state == eepr_pkg::ST_PROG;
    endproperty
    a_stop_prog: assert property (p_stop_prog) else $error("write cycle not started at stop");

    property p_prog_len;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (state == eepr_pkg::ST_PROG && next_state == eepr_pkg::ST_IDLE) |-> tmr == TMR_W'(WR_CYCLES - 1);
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("write cycle ended early");

    property p_wp_push;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        push |-> !wp_s && !(swp && !addr_cnt[eepr_pkg::PROT_BIT]);
    endproperty
    a_wp_push: assert property (p_wp_push) else $error("protected byte queued for programming");

    property p_reg_once;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (swp || wp_s) && state == eepr_pkg::ST_ADDR && next_state == eepr_pkg::ST_ADDR_ACK |=> !is_reg;
    endproperty
    a_reg_once: assert property (p_reg_once) else $error("protection register acknowledged again");

    property p_lock_stays;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        swp_wr |=> swp_wr;
    endproperty
    a_lock_stays: assert property (p_lock_stays) else $error("software lock cleared");

    property p_read_inc;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (state == eepr_pkg::ST_RDATA && scl_fall && bitcnt == eepr_pkg::BIT_LAST && !start_det && !stop_det)
        |=> addr_cnt == $past(addr_cnt) + 8'h01;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read counter not advanced by one");

    property p_page_hi;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        push |=> addr_cnt[AW-1:eepr_pkg::PAGE_BITS] == $past(addr_cnt[AW-1:eepr_pkg::PAGE_BITS])
            && addr_cnt[eepr_pkg::PAGE_BITS-1:0] == $past(addr_cnt[eepr_pkg::PAGE_BITS-1:0]) + 1'b1;
    endproperty
    a_page_hi: assert property (p_page_hi) else $error("page write changed upper address bits");

    property p_rand_load;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (state == eepr_pkg::ST_WADDR && next_state == eepr_pkg::ST_WADDR_ACK && !is_reg)
        |=> addr_cnt == $past(shreg) ##1 state != eepr_pkg::ST_RDATA || addr_cnt == $past(addr_cnt);
    endproperty
    a_rand_load: assert property (p_rand_load) else $error("byte address not loaded");

    property p_nack_end;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (state == eepr_pkg::ST_RACK && scl_fall && !mack && !start_det && !stop_det)
        |=> state == eepr_pkg::ST_WAIT_STOP && !o_sda_oe;
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read not ended on master no-ack");
endmodule : eepr_core

//--- testbench/eepr_mst.sv
// Bus master model that drives the clock and data of the two-wire link
`timescale 1ns/1ps
module eepr_mst (
    // Clock
    input wire logic i_clk_sys,
    // Link
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // Clock stands high and data released between frames
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : wt
    task automatic start();
        wt(2);
        o_sda = 1'b1;
        wt(2);
        o_scl = 1'b1;
        wt(4);
        o_sda = 1'b0;
        wt(4);
        o_scl = 1'b0;
    endtask : start
    task automatic stop();
        wt(2);
        o_sda = 1'b0;
        wt(2);
        o_scl = 1'b1;
        wt(4);
        o_sda = 1'b1;
        wt(4);
    endtask : stop
    // One link period; data sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        wt(2);
        o_sda = b;
        wt(2);
        o_scl = 1'b1;
        wt(3);
        s = i_sda;
        wt(1);
        o_scl = 1'b0;
    endtask : bit_io
    // byte sent msb first, slot released
    task automatic wbyte(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= 0; i--) bit_io(b[i], ack_n);
        bit_io(1'b1, ack_n);
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic x;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(nack, x);
    endtask : rbyte
endmodule : eepr_mst

//--- testbench/tb_top.sv
// Self-checking bench of the two-wire EEPROM access logic
`timescale 1ns/1ps
module tb_top;
    localparam logic [2:0] CS = 3'h5;
    localparam logic [7:0] SA_W = {eepr_pkg::MEM_NIBBLE, CS, 1'b0};
    localparam logic [7:0] SA_R = {eepr_pkg::MEM_NIBBLE, CS, 1'b1};
    localparam logic [7:0] SA_P = {eepr_pkg::REG_NIBBLE, CS, 1'b0};
    logic clk_sys, resetn, scl, m_sda, sda_o, sda_oe, wp, prog, busy, s;
    logic stored = 1'b0;
    logic [7:0] d;
    wire sda;
    int miscompares = 0;
    int compares = 0;
    // Open-drain wire with pull-up
    assign sda = m_sda & (sda_oe ? sda_o : 1'b1);
    eepr_core #(.WR_CYCLES(200)) u_dut (
        .i_clk_sys(clk_sys), .i_resetn(resetn),
        .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .i_chip_select_inputs(CS), .i_wp(wp),
        .i_swp_stored(stored), .o_swp_program(prog), .o_busy(busy)
    );
    eepr_mst u_mst (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
    // Lock cell keeps its value through reset
    always @(negedge clk_sys) begin
        if (prog === 1'b1) stored <= 1'b1;
    end
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Write transfer, then polling until the device answers
    task automatic wr(input logic [7:0] sa, a, dv, input int n, input logic ack_e, busy_e);
        u_mst.start();
        u_mst.wbyte(sa, s);
        chk(8'(s), 8'(ack_e), "address ack");
        if (s === 1'b0) begin
            u_mst.wbyte(a, s);
            chk(8'(s), 8'h0, "byte address ack");
            for (int i = 0; i < n; i++) begin
                u_mst.wbyte(dv + 8'(i), s);
                chk(8'(s), 8'(i >= 32), "data ack");
            end
        end
        u_mst.stop();
        for (int t = 0; t < 10; t++) begin
            u_mst.start();
            if (t == 0) chk(8'(busy), 8'(busy_e), "write cycle");
            u_mst.wbyte(SA_W, s);
            u_mst.stop();
            if (t == 0) chk(8'(s), 8'(busy_e), "first poll");
            if (s === 1'b0) break;
        end
        if (s !== 1'b0) begin
            chk(8'(s), 8'h0, "poll ack");
            complete_run();
        end
    endtask : wr
    // Random or current read of one or two bytes
    task automatic rd(input logic rnd, input logic [7:0] a, e0, e1, input int n);
        if (rnd) begin
            u_mst.start();
            u_mst.wbyte(SA_W, s);
            u_mst.wbyte(a, s);
            chk(8'(s), 8'h0, "byte address ack");
        end
        u_mst.start();
        u_mst.wbyte(SA_R, s);
        chk(8'(s), 8'h0, "read address ack");
        for (int i = 0; i < n; i++) begin
            u_mst.rbyte(i == n - 1, d);
            chk(d, i == 0 ? e0 : e1, "read data");
        end
        u_mst.wt(4);
        chk(8'(sda_oe), 8'h0, "released after nack");
        u_mst.stop();
    endtask : rd
    task automatic s_write_poll();
        wr(SA_W, 8'h10, 8'h11, 1, 1'b0, 1'b1);
        wr(SA_W, 8'h90, 8'h5a, 1, 1'b0, 1'b1);
    endtask : s_write_poll
    // Page wrap, full buffer refusal, read wrap at the top
    task automatic s_page_read();
        wr(SA_W, 8'hff, 8'hc0, 2, 1'b0, 1'b1);
        wr(SA_W, 8'h00, 8'h77, 1, 1'b0, 1'b1);
        wr(SA_W, 8'ha0, 8'h40, 33, 1'b0, 1'b1);
        rd(1'b1, 8'ha0, 8'h50, 8'h51, 2);
        rd(1'b1, 8'hff, 8'hc0, 8'h77, 2);
        rd(1'b1, 8'hff, 8'hc0, 8'h00, 1);
        rd(1'b0, 8'h00, 8'h77, 8'h00, 1);
        rd(1'b1, 8'hf0, 8'hc1, 8'h00, 1);
    endtask : s_page_read
    task automatic s_refuse();
        wr({eepr_pkg::MEM_NIBBLE, ~CS, 1'b0}, 8'h00, 8'h00, 0, 1'b1, 1'b0);
        wr({eepr_pkg::REG_NIBBLE, CS, 1'b1}, 8'h00, 8'h00, 0, 1'b1, 1'b0);
        wp = 1'b1;
        wr(SA_W, 8'h90, 8'ha5, 1, 1'b0, 1'b0);
        wr(SA_P, 8'h00, 8'h00, 1, 1'b1, 1'b0);
        wp = 1'b0;
        rd(1'b1, 8'h90, 8'h5a, 8'h00, 1);
        chk(8'(stored), 8'h0, "no lock");
    endtask : s_refuse
    task automatic s_sw_lock();
        wr(SA_P, 8'h00, 8'h3c, 1, 1'b0, 1'b1);
        chk(8'(stored), 8'h1, "lock set");
        wr(SA_W, 8'h10, 8'h22, 1, 1'b0, 1'b0);
        rd(1'b1, 8'h10, 8'h11, 8'h00, 1);
        wr(SA_W, 8'h90, 8'h66, 1, 1'b0, 1'b1);
        rd(1'b1, 8'h90, 8'h66, 8'h00, 1);
        wr(SA_P, 8'h00, 8'h00, 1, 1'b1, 1'b0);
    endtask : s_sw_lock
    task automatic s_reset_lock();
        resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (8) @(negedge clk_sys);
        wr(SA_P, 8'h00, 8'h00, 1, 1'b1, 1'b0);
        wr(SA_W, 8'h7f, 8'h01, 1, 1'b0, 1'b0);
        rd(1'b1, 8'h10, 8'h11, 8'h00, 1);
    endtask : s_reset_lock
    initial begin
        resetn = 1'b0;
        wp = 1'b0;
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (8) @(negedge clk_sys);
        s_write_poll();
        s_page_read();
        s_refuse();
        s_sw_lock();
        s_reset_lock();
        complete_run();
    end
endmodule : tb_top
